// [hw/vcarb_regs.sv]
// virtual-channel arbitration registers: capability 2, port control, port status,
// staged and active arbitration tables with a load sequencer
// assumes config accesses are synchronous to clk, one per cycle, dword aligned
`timescale 1ns/1ps
`include "vcarb_consts.svh"

module vcarb_regs
    import vcarb_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 strict_priority_en,
    input  wire vcarb_cfg_req_s       cfg_req,
    output logic [31:0]               cfg_rdata,
    output logic                      cfg_rvalid,
    output logic [2:0]                arb_scheme_select,
    output logic [2:0]                low_priority_count,
    output logic [`VCARB_TBL_WORDS*32-1:0] arb_table_active
);

    vcarb_state_e                state_r;
    vcarb_state_e                state_nxt;
    logic [`VCARB_TBL_IDX_W-1:0] idx_r;
    logic [`VCARB_TBL_IDX_W-1:0] idx_nxt;
    logic                        arb_table_pending_r;
    logic                        arb_table_pending_nxt;
    logic                        dirty_r;
    logic                        dirty_nxt;
    logic [31:0]                 rdata_nxt;
    vcarb_word_t                 staged_r [`VCARB_TBL_WORDS];
    vcarb_word_t                 active_r [`VCARB_TBL_WORDS];
    logic [`VCARB_TBL_WORDS-1:0] stage_hit;

    // decode
    wire        hit_cap2    = cfg_req.addr == `VCARB_OFF_CAP2;
    wire        hit_ctrl    = cfg_req.addr == `VCARB_OFF_CTRL;
    wire        ctrl_wr     = cfg_req.wr && hit_ctrl && cfg_req.be[0];
    wire        arb_table_load = ctrl_wr && cfg_req.wdata[`VCARB_CTRL_LOAD_BIT];
    wire        scratch     = low_priority_count == `VCARB_LPC_STRICT;
    wire        stage_wr    = |stage_hit;
    wire        copy_last   = state_r == VCARB_COPY && idx_r == `VCARB_TBL_IDX_W'(`VCARB_TBL_WORDS - 1);
    wire        copy_done   = copy_last && !arb_table_load;
    wire [7:0]  arb_table_offset = scratch ? `VCARB_TBL_OFFSET_OFF : `VCARB_TBL_OFFSET_ON;
    wire [7:0]  arb_scheme_mask  = scratch ? `VCARB_MASK_OFF : `VCARB_MASK_ON;
    wire [31:0] cap2_word   = {arb_table_offset, 16'h0000, arb_scheme_mask};
    wire [31:0] ctrl_word   = {15'h0000, arb_table_pending_r, 12'h000,
                               arb_scheme_select, 1'b0};

    // staged table entries and their active copies
    genvar g;
    generate
        for (g = 0; g < `VCARB_TBL_WORDS; g = g + 1) begin : g_entry
            wire [11:0] entry_addr = 12'(`VCARB_OFF_TABLE + 4 * g);
            wire        copy_this  = state_r == VCARB_COPY && idx_r == `VCARB_TBL_IDX_W'(g);
            assign stage_hit[g] = cfg_req.wr && cfg_req.addr == entry_addr && |cfg_req.be;
            assign arb_table_active[g*32 +: 32] = active_r[g];

            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    staged_r[g] <= 32'h0000_0000;
                end else begin
                    for (int b = 0; b < 4; b++) begin
                        if (stage_hit[g] && cfg_req.be[b]) begin
                            staged_r[g][b*8 +: 8] <= cfg_req.wdata[b*8 +: 8];
                        end
                    end
                end
            end

            // scratch mode loads zeros so table contents cannot steer arbitration
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    active_r[g] <= 32'h0000_0000;
                end else if (copy_this) begin
                    active_r[g] <= scratch ? 32'h0000_0000 : staged_r[g];
                end
            end
        end
    endgenerate

    // load sequencer: one entry per cycle; a new load restarts from entry zero
    always_comb begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        case (state_r)
            VCARB_IDLE: begin
                if (arb_table_load) begin
                    state_nxt = VCARB_COPY;
                    idx_nxt   = '0;
                end
            end
            VCARB_COPY: begin
                if (arb_table_load) begin
                    idx_nxt = '0;
                end else if (copy_last) begin
                    state_nxt = VCARB_IDLE;
                    idx_nxt   = '0;
                end else begin
                    idx_nxt = idx_r + 1'b1;
                end
            end
            default: begin
                state_nxt = VCARB_IDLE;
                idx_nxt   = '0;
            end
        endcase
    end

    // edits made during a copy may miss entries already copied, so they keep pending set
    assign dirty_nxt = (arb_table_load && state_nxt == VCARB_COPY) ? stage_wr
                     : (dirty_r || (stage_wr && state_r == VCARB_COPY));
    assign arb_table_pending_nxt = stage_wr
                                 || (arb_table_pending_r && !(copy_done && !dirty_r));

    assign rdata_nxt = hit_cap2 ? cap2_word : (hit_ctrl ? ctrl_word : 32'h0000_0000);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r             <= VCARB_IDLE;
            idx_r               <= '0;
            dirty_r             <= 1'b0;
            arb_table_pending_r <= 1'b0;
        end else begin
            state_r             <= state_nxt;
            idx_r               <= idx_nxt;
            dirty_r             <= dirty_nxt;
            arb_table_pending_r <= arb_table_pending_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            arb_scheme_select <= `VCARB_SEL_RESET;
        end else if (ctrl_wr) begin
            arb_scheme_select <= cfg_req.wdata[`VCARB_CTRL_SEL_MSB:`VCARB_CTRL_SEL_LSB];
        end
    end

    // strap-like level followed every cycle, never taken under reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            low_priority_count <= `VCARB_LPC_RESET;
        end else begin
            low_priority_count <= strict_priority_en ? `VCARB_LPC_STRICT : `VCARB_LPC_NORMAL;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_req.rd;
            if (cfg_req.rd) begin
                cfg_rdata <= rdata_nxt;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_TBL_OFFSET: assert property (
        cfg_req.rd && hit_cap2 |=> cfg_rvalid
            && cfg_rdata[31:24] == ($past(low_priority_count) == 3'h0 ? 8'h00 : 8'h03))
        else $error("table offset field wrong for low-priority count");

    AST_CAP2_RSVD: assert property (
        cfg_req.rd && hit_cap2 |=> cfg_rdata[23:8] == 16'h0000)
        else $error("capability 2 reserved bits not zero");

    AST_SCHEME_MASK: assert property (
        cfg_req.rd && hit_cap2 |=> cfg_rdata[7:0] == ($past(low_priority_count) == 3'h0 ? 8'h00 : 8'h03))
        else $error("scheme mask wrong for low-priority count");

    AST_CTRL_RSVD: assert property (
        cfg_req.rd && hit_ctrl |=> cfg_rdata[15:4] == 12'h000 && cfg_rdata[3:1] == $past(arb_scheme_select))
        else $error("control reserved bits or select misread");

    AST_LOAD_READS_ZERO: assert property (
        ctrl_wr ##[1:4] cfg_req.rd && hit_ctrl |=> cfg_rdata[0] == 1'b0)
        else $error("load command bit read back as one");

    AST_STAT_RSVD: assert property (
        cfg_req.rd && hit_ctrl |=> cfg_rdata[31:17] == 15'h0000 && cfg_rdata[16] == $past(arb_table_pending_r))
        else $error("status reserved bits not zero");

    AST_SELECT_WRITE: assert property (
        ctrl_wr |=> arb_scheme_select == $past(cfg_req.wdata[3:1]))
        else $error("scheme select did not take written value");

    AST_LOAD_COPIES: assert property (
        arb_table_load && state_r == VCARB_IDLE && !scratch && !strict_priority_en && !stage_hit[0]
            |=> state_r == VCARB_COPY ##1 active_r[0] == $past(staged_r[0], 2))
        else $error("load did not copy first staged entry");

    AST_SCRATCH_ZERO: assert property (
        state_r == VCARB_COPY && scratch |=> arb_table_active[$past(idx_r)*32 +: 32] == 32'h0000_0000)
        else $error("scratch table reached active copy");

    AST_PENDING_SET: assert property (
        stage_wr |=> arb_table_pending_r)
        else $error("staged write did not set pending");

    AST_PENDING_CLR: assert property (
        $fell(arb_table_pending_r) |-> $past(copy_done) && $past(state_r) == VCARB_COPY)
        else $error("pending cleared without finished load");

    AST_LOAD_BOUND: assert property (
        arb_table_load && !stage_wr ##1 (!arb_table_load && !stage_wr) [*4] |=> !arb_table_pending_r)
        else $error("pending still set after undisturbed load");

    AST_LPC: assert property (
        ##1 low_priority_count == ($past(strict_priority_en) ? 3'h0 : 3'h1))
        else $error("low-priority count does not follow strict mode");

    AST_ACTIVE_HOLD: assert property (
        state_r == VCARB_IDLE |=> $stable(arb_table_active))
        else $error("active table changed without a load");

    AST_SELECT_HOLD: assert property (
        !ctrl_wr |=> $stable(arb_scheme_select))
        else $error("scheme select changed without a control write");

    AST_LOAD_START: assert property (
        arb_table_load |=> state_r == VCARB_COPY && idx_r == 2'h0)
        else $error("load did not start copying at entry zero");

    AST_SCRATCH_CAP2: assert property (
        cfg_req.rd && hit_cap2 && scratch |=> cfg_rdata == 32'h0000_0000)
        else $error("capability 2 not all zero in scratch mode");

    // pending may only fall from inside a copy, so an idle bank keeps it
    AST_PENDING_HOLD: assert property (
        arb_table_pending_r && state_r == VCARB_IDLE |=> arb_table_pending_r)
        else $error("pending cleared while no load was running");

    AST_STAGE_ONLY: assert property (
        stage_wr && state_r == VCARB_IDLE && !arb_table_load |=> $stable(arb_table_active))
        else $error("staged write reached the active table");

    AST_RVALID_PULSE: assert property (
        cfg_req.rd |=> cfg_rvalid)
        else $error("read not answered one cycle later");

endmodule : vcarb_regs

// [shared/vcarb_consts.svh]
// constants for the virtual-channel arbitration register bank
// assumes a config port carrying 12-bit byte addresses, dword aligned with byte enables
`ifndef VCARB_CONSTS_SVH
`define VCARB_CONSTS_SVH

`define VCARB_CAP_BASE        12'h150
`define VCARB_OFF_CAP2        12'h158
`define VCARB_OFF_CTRL        12'h15c
`define VCARB_OFF_STAT        12'h15e
`define VCARB_TBL_OFF_BYTES   12'h030
`define VCARB_OFF_TABLE       (`VCARB_CAP_BASE + `VCARB_TBL_OFF_BYTES)
`define VCARB_TBL_WORDS       4
`define VCARB_TBL_IDX_W       2

`define VCARB_TBL_OFFSET_LSB  24
`define VCARB_TBL_OFFSET_ON   8'h03
`define VCARB_TBL_OFFSET_OFF  8'h00
`define VCARB_MASK_ON         8'h03
`define VCARB_MASK_OFF        8'h00

`define VCARB_CTRL_LOAD_BIT   0
`define VCARB_CTRL_SEL_LSB    1
`define VCARB_CTRL_SEL_MSB    3
`define VCARB_STAT_LSB        16
`define VCARB_SEL_RESET       3'h0
`define VCARB_SEL_RR          3'h0
`define VCARB_SEL_WRR32       3'h1
`define VCARB_LPC_STRICT      3'h0
`define VCARB_LPC_NORMAL      3'h1
`define VCARB_LPC_RESET       3'h1

`endif

// [shared/vcarb_pkg.sv]
// types for the virtual-channel arbitration register bank
// constant values live in vcarb_consts.svh
package vcarb_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } vcarb_cfg_req_s;

    typedef enum logic [0:0] {
        VCARB_IDLE,
        VCARB_COPY
    } vcarb_state_e;

    typedef logic [31:0] vcarb_word_t;

endpackage : vcarb_pkg

// [bench/vcarb_regs_tb.sv]
// self-checking bench for vcarb_regs: capability and control reads, table staging, load and strict mode
// assumes the design answers each config read one cycle later and takes one request per cycle
`timescale 1ns/1ps
`include "vcarb_consts.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end

module vcarb_regs_tb import vcarb_pkg::*;;
    logic                          clk                = 1'b0;
    logic                          reset_n            = 1'b0;
    logic                          strict_priority_en = 1'b0;
    vcarb_cfg_req_s                req                = '0;
    logic [31:0]                   cfg_rdata;
    logic                          cfg_rvalid;
    logic [2:0]                    arb_scheme_select;
    logic [2:0]                    low_priority_count;
    logic [`VCARB_TBL_WORDS*32-1:0] arb_table_active;
    vcarb_word_t                   exp_q[$];
    vcarb_word_t                   mon_exp;
    vcarb_word_t                   tbl[4];
    int                            num_errors         = 0;
    int                            compares           = 0;

    vcarb_regs u_dut (
        .clk                (clk),
        .reset_n            (reset_n),
        .strict_priority_en (strict_priority_en),
        .cfg_req            (req),
        .cfg_rdata          (cfg_rdata),
        .cfg_rvalid         (cfg_rvalid),
        .arb_scheme_select  (arb_scheme_select),
        .low_priority_count (low_priority_count),
        .arb_table_active   (arb_table_active)
    );

    always #50 clk = ~clk;

    // read answers arrive in request order, so the oldest note always matches
    always @(posedge clk) begin
        if (cfg_rvalid === 1'b1) begin
            mon_exp = exp_q.pop_front();
            `CHK(cfg_rdata, mon_exp)
        end
    end

    task automatic stop_test();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic cfg_wr(input logic [11:0] a, input logic [3:0] be, input vcarb_word_t d);
        @(posedge clk);
        #1;
        req.wr    = 1'b1;
        req.addr  = a;
        req.be    = be;
        req.wdata = d;
        @(posedge clk);
        #1;
        req.wr    = 1'b0;
    endtask : cfg_wr

    task automatic cfg_rd(input logic [11:0] a, input vcarb_word_t exp);
        @(posedge clk);
        #1;
        req.rd   = 1'b1;
        req.addr = a;
        exp_q.push_back(exp);
        @(posedge clk);
        #1;
        req.rd   = 1'b0;
    endtask : cfg_rd

    initial begin
        #(3000 * 100);
        num_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        stop_test();
    end

    initial begin
        void'($urandom(32'hc2a7));
        repeat (4) @(posedge clk);
        #1;
        reset_n = 1'b1;
        cfg_rd(12'h158, 32'h0300_0003);
        cfg_rd(12'h15c, 32'h0000_0000);
        cfg_rd(12'h1f0, 32'h0000_0000);
        cfg_wr(12'h158, 4'hf, 32'hffff_ffff);
        cfg_rd(12'h158, 32'h0300_0003);
        `CHK(low_priority_count, 3'h1)
        $display("test reset_values done");
        // reserved bits set on purpose; the load bit rides along and must read back as zero
        for (int v = 1; v >= 0; v--) begin
            cfg_wr(12'h15c, 4'h3, 32'h0000_fff1 | (v << 1));
            cfg_rd(12'h15c, {28'h0, 3'(v), 1'b0});
            `CHK(arb_scheme_select, 3'(v))
        end
        cfg_wr(12'h15c, 4'he, 32'h0000_0002);
        cfg_rd(12'h15c, 32'h0000_0000);
        $display("test control done");
        for (int i = 0; i < 4; i++) begin
            tbl[i] = $urandom();
            cfg_wr(12'h180 + 12'(4 * i), 4'hf, tbl[i]);
        end
        cfg_wr(12'h188, 4'h5, 32'hffff_ffff);
        tbl[2] = tbl[2] | 32'h00ff_00ff;
        cfg_rd(12'h184, 32'h0000_0000);
        cfg_rd(12'h15c, 32'h0001_0000);
        `CHK(arb_table_active, 128'h0)
        cfg_wr(12'h15c, 4'h1, 32'h0000_0001);
        cfg_rd(12'h15c, 32'h0001_0000);
        repeat (4) @(posedge clk);
        cfg_rd(12'h15c, 32'h0000_0000);
        `CHK(arb_table_active, {tbl[3], tbl[2], tbl[1], tbl[0]})
        $display("test table_load done");
        strict_priority_en = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(low_priority_count, 3'h0)
        cfg_rd(12'h158, 32'h0000_0000);
        cfg_wr(12'h180, 4'hf, $urandom());
        cfg_rd(12'h15c, 32'h0001_0000);
        cfg_wr(12'h15c, 4'h1, 32'h0000_0001);
        repeat (6) @(posedge clk);
        cfg_rd(12'h15c, 32'h0000_0000);
        // in scratch mode the staged words must not steer the arbiter
        `CHK(arb_table_active, 128'h0)
        strict_priority_en = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(low_priority_count, 3'h1)
        $display("test strict_mode done");
        repeat (3) @(posedge clk);
        `CHK(exp_q.size(), 0)
        stop_test();
    end
endmodule : vcarb_regs_tb
